/* File: bench/rcsog_i2c_master.sv */
// Purpose: serial bus master driving the block's i2c pins
// Assumes: pull-up on both lines, device only pulls data low
// Notes: scl stands high between frames, 320 ns bit period
`timescale 1ns/1ps
module rcsog_i2c_master (
	// open-drain lines, 1 releases
	output logic scl,
	output logic sda_drv,
	// resolved data line
	input wire logic sda_line
);
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	// data moves 40 ns after scl falls, so it never looks like start or stop
	task automatic put_bit(input logic b, output logic got);
		sda_drv = b;
		#120;
		scl = 1'b1;
		#150;
		got = sda_line;
		#10;
		scl = 1'b0;
		#40;
	endtask : put_bit

	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic got;
		for (int i = 7; i >= 0; i--) begin
			put_bit(d[i], got);
		end
		put_bit(1'b1, got);
		ack = ~got;
	endtask : send_byte

	task automatic command(input logic [7:0] addr, input logic [7:0] cmd,
		input logic with_cmd, output logic ack_a, output logic ack_c);
		sda_drv = 1'b0;
		#160;
		scl = 1'b0;
		#40;
		send_byte(addr, ack_a);
		ack_c = 1'b0;
		if (with_cmd && ack_a) begin
			send_byte(cmd, ack_c);
		end
		sda_drv = 1'b0;
		#120;
		scl = 1'b1;
		#160;
		sda_drv = 1'b1;
		#160;
	endtask : command
endmodule : rcsog_i2c_master

/* File: bench/rcsog_top_assertions.sv */
// Purpose: port-level checks of source switching, otp and gating
// Assumes: bench moves pins on sys_clk edges
// Notes: otp length handed in by the bind
`timescale 1ns/1ps
module rcsog_chk #(
	parameter int NUM_OUT = 3,
	parameter int OTP_CYC = 50
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// watched ports
	input wire logic reg_wr,
	input wire logic input_source_select_pin,
	input wire logic shutdown_enable_pin,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_oe_n,
	input wire logic ref_sel_diff,
	input wire logic ref_gate_en,
	input wire logic [rcsog_pkg::XTAL_W-1:0] crystal_load_trim,
	input wire logic [2*NUM_OUT-1:0] out_mode,
	input wire logic global_shutdown,
	input wire logic otp_busy
);
	logic [15:0] busy_run_reg;
	logic [3:0] stop_age_reg;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) busy_run_reg <= '0;
		else busy_run_reg <= otp_busy ? busy_run_reg + 16'h0001 : 16'h0000;
	end

	// stop seen on raw pins, age saturates
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) stop_age_reg <= 4'hf;
		else if (scl_in && $rose(sda_in)) stop_age_reg <= 4'h0;
		else if (stop_age_reg != 4'hf) stop_age_reg <= stop_age_reg + 4'h1;
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	a_busy_no_ack: assert property (
		otp_busy && $past(otp_busy) |-> sda_oe_n)
		else $error("ack driven during otp operation");
	a_busy_cause: assert property (
		$rose(otp_busy) |-> $past(reg_wr) || $past(reg_wr, 2) || stop_age_reg < 4'ha)
		else $error("otp operation started without stop or write");
	a_busy_len: assert property (
		busy_run_reg <= 16'(OTP_CYC + 3))
		else $error("otp operation too long");
	a_tri_busy: assert property (
		$past(otp_busy) |-> out_mode == {NUM_OUT{2'h2}})
		else $error("outputs driven before configuration loaded");
	a_sel_gated: assert property (
		$changed(ref_sel_diff) |-> !ref_gate_en && !$past(ref_gate_en))
		else $error("source moved while outputs ungated");
	a_gate_hold: assert property (
		$fell(ref_gate_en) |-> !ref_gate_en [*8])
		else $error("gate gap too short");
	a_gate_bound: assert property (
		$fell(ref_gate_en) |-> ##[1:20] ref_gate_en)
		else $error("outputs left gated");
	a_sel_sync: assert property (
		$changed(input_source_select_pin) && !reg_wr && !$past(reg_wr)
		|=> $stable(ref_gate_en) && $stable(ref_sel_diff))
		else $error("select pin acted without synchroniser");
	a_sd_sync: assert property (
		$changed(shutdown_enable_pin) && !reg_wr && !$past(reg_wr)
		|=> $stable(out_mode) && $stable(global_shutdown))
		else $error("shutdown pin acted without synchroniser");
	a_trim_cause: assert property (
		$changed(crystal_load_trim) |-> $past(reg_wr) || $past(otp_busy))
		else $error("trim changed without write or restore");
	a_shdn_all: assert property (
		global_shutdown |-> out_mode == {NUM_OUT{2'h3}})
		else $error("global shutdown left an output running");
endmodule : rcsog_chk

bind rcsog_top rcsog_chk #(.NUM_OUT(NUM_OUT), .OTP_CYC(OTP_CYC)) u_chk (
	.sys_clk(sys_clk), .nrst(nrst), .reg_wr(reg_wr),
	.input_source_select_pin(input_source_select_pin),
	.shutdown_enable_pin(shutdown_enable_pin), .scl_in(scl_in), .sda_in(sda_in),
	.sda_oe_n(sda_oe_n), .ref_sel_diff(ref_sel_diff), .ref_gate_en(ref_gate_en),
	.crystal_load_trim(crystal_load_trim), .out_mode(out_mode),
	.global_shutdown(global_shutdown), .otp_busy(otp_busy));

/* File: bench/ref_clock_select_otp_output_gate_tb_top.sv */
// Purpose: self-checking bench of the reference select, otp and gating block
// Assumes: otp length raised so a busy nack fits inside one operation
// Notes: reset reloads the factory otp image over any saved one, so later checks avoid trim
`timescale 1ns/1ps
module ref_clock_select_otp_output_gate_tb_top;
	localparam int NOUT = 3;
	localparam int OTPC = 200;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic sel_pin = 1'b0;
	logic sd_pin = 1'b0;
	wire logic scl;
	wire logic sda_drv;
	wire logic sda_line;
	logic [7:0] reg_rdata;
	logic sda_out;
	logic sda_oe_n;
	logic ref_sel_diff;
	logic ref_gate_en;
	logic global_shutdown;
	logic otp_busy;
	logic [5:0] trim;
	logic [2*NOUT-1:0] out_mode;
	int miscompares = 0;
	int num_checks = 0;

	always #20 sys_clk = ~sys_clk;
	// pull-up: line low only when someone pulls it
	assign sda_line = sda_drv & (sda_oe_n | sda_out);

	rcsog_top #(.NUM_OUT(NOUT), .OTP_CYC(OTPC)) u_dut (
		.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.input_source_select_pin(sel_pin), .shutdown_enable_pin(sd_pin),
		.scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.ref_sel_diff(ref_sel_diff), .ref_gate_en(ref_gate_en),
		.crystal_load_trim(trim), .out_mode(out_mode),
		.global_shutdown(global_shutdown), .otp_busy(otp_busy));

	rcsog_i2c_master u_mst (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));

	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_sim

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, e);
	endtask : rd_chk

	// lets a just-requested operation raise busy before polling
	task automatic wait_idle();
		int n = 0;
		repeat (8) @(posedge sys_clk);
		while (otp_busy !== 1'b0 && n < OTPC + 40) begin
			@(posedge sys_clk);
			n++;
		end
		check(8'(otp_busy), 8'h00);
	endtask : wait_idle

	function automatic logic [1:0] exp_mode(input logic sh, input logic sp, input logic pin,
		input logic drv, input logic gate);
		if (sh && pin) return 2'h3;
		if (!drv) return 2'h2;
		if (gate && (pin ^ sp)) return 2'h1;
		return 2'h0;
	endfunction : exp_mode

	initial begin
		#1_000_000;
		miscompares++;
		end_sim();
	end

	initial begin
		logic [7:0] t;
		logic [7:0] dv;
		logic [7:0] gt;
		logic aa;
		logic ac;
		void'($urandom(32'hc37b));
		repeat (16) @(posedge sys_clk);
		nrst <= 1'b1;
		wait_idle();
		rd_chk(rcsog_pkg::REG_XTAL, rcsog_pkg::OTP_FACTORY[23:16]);
		rd_chk(rcsog_pkg::REG_DRV_EN, rcsog_pkg::OTP_FACTORY[39:32]);
		rd_chk(rcsog_pkg::REG_STATUS, 8'h08);
		rd_chk(8'h40, 8'h00);
		rd_chk(rcsog_pkg::REG_OTP_CMD, 8'h00);
		for (int i = 0; i < 6; i++) begin
			t = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
			wr(rcsog_pkg::REG_XTAL, t);
			rd_chk(rcsog_pkg::REG_XTAL, t & 8'h3f);
			check(8'(trim), t & 8'h3f);
		end
		for (int k = 0; k < 8; k++) begin
			wr(rcsog_pkg::REG_SRC, {1'b0, k[2], 4'h0, k[0], 1'b0});
			repeat (20) @(posedge sys_clk);
			sel_pin <= k[1];
			repeat (20) @(posedge sys_clk);
			check(8'(ref_sel_diff), 8'(k[0] ^ k[1]));
			check(8'(ref_gate_en), 8'h01);
		end
		// upper mode bit set: pin no longer steers the source
		wr(rcsog_pkg::REG_SRC, 8'h82);
		repeat (20) @(posedge sys_clk);
		sel_pin <= 1'b0;
		repeat (20) @(posedge sys_clk);
		check(8'(ref_sel_diff), 8'h00);
		for (int k = 0; k < 16; k++) begin
			dv = 8'($urandom);
			gt = (k < 8) ? 8'hff : 8'($urandom);
			sd_pin <= k[2];
			repeat (2) @(posedge sys_clk);
			wr(rcsog_pkg::REG_OUT_CTRL, {6'h00, k[1], k[0]});
			wr(rcsog_pkg::REG_DRV_EN, dv);
			wr(rcsog_pkg::REG_GATE_EN, gt);
			repeat (6) @(posedge sys_clk);
			for (int o = 0; o < NOUT; o++) begin
				t = 8'(exp_mode(k[0], k[1], k[2], dv[o], gt[o]));
				check(8'(out_mode[2*o +: 2]), t);
			end
			check(8'(global_shutdown), 8'(k[0] & k[2]));
		end
		wr(rcsog_pkg::REG_XTAL, 8'h2a);
		u_mst.command(8'hd4, rcsog_pkg::CMD_RESTORE, 1'b1, aa, ac);
		check(8'({aa, ac}), 8'h03);
		repeat (4) @(posedge sys_clk);
		check(8'(otp_busy), 8'h01);
		u_mst.command(8'hd4, 8'h00, 1'b0, aa, ac);
		check(8'(aa), 8'h00);
		wait_idle();
		rd_chk(rcsog_pkg::REG_XTAL, rcsog_pkg::OTP_FACTORY[23:16]);
		t = {2'b00, 6'($urandom)};
		wr(rcsog_pkg::REG_XTAL, t);
		u_mst.command(8'hd4, rcsog_pkg::CMD_SAVE, 1'b1, aa, ac);
		check(8'({aa, ac}), 8'h03);
		wait_idle();
		wr(rcsog_pkg::REG_XTAL, ~t);
		wr(rcsog_pkg::REG_OTP_CMD, 8'h01);
		repeat (2) @(posedge sys_clk);
		check(8'(otp_busy), 8'h01);
		rd_chk(rcsog_pkg::REG_STATUS, 8'h09);
		wait_idle();
		rd_chk(rcsog_pkg::REG_XTAL, t);
		// both command bits in one write: save wins
		wr(rcsog_pkg::REG_XTAL, t ^ 8'h15);
		wr(rcsog_pkg::REG_OTP_CMD, 8'h09);
		wait_idle();
		wr(rcsog_pkg::REG_XTAL, t);
		wr(rcsog_pkg::REG_OTP_CMD, 8'h01);
		wait_idle();
		rd_chk(rcsog_pkg::REG_XTAL, t ^ 8'h15);
		wr(rcsog_pkg::REG_ADDR_SEL, 8'h01);
		u_mst.command(8'hd4, 8'h00, 1'b0, aa, ac);
		check(8'(aa), 8'h00);
		u_mst.command(8'hd1, 8'h00, 1'b0, aa, ac);
		check(8'(aa), 8'h00);
		u_mst.command(8'hd0, 8'h55, 1'b1, aa, ac);
		check(8'(aa), 8'h01);
		repeat (8) @(posedge sys_clk);
		check(8'(otp_busy), 8'h00);
		@(posedge sys_clk);
		nrst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		wait_idle();
		rd_chk(rcsog_pkg::REG_ADDR_SEL, 8'h00);
		u_mst.command(8'hd4, 8'h00, 1'b0, aa, ac);
		check(8'(aa), 8'h01);
		end_sim();
	end
endmodule : ref_clock_select_otp_output_gate_tb_top

/* File: logic/rcsog_pkg.sv */
// Purpose: shared constants and types of the reference select, otp and output gate block
// Assumes: 8-bit register port, one aligned register per address
// Notes: i2c addresses are held as 7-bit values, write byte is {addr, 1'b0}
package rcsog_pkg;

	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	localparam int NUM_CFG = 6;
	localparam int XTAL_W = 6;

	// register addresses
	localparam logic [7:0] REG_ADDR_SEL = 8'h00;
	localparam logic [7:0] REG_OUT_CTRL = 8'h10;
	localparam logic [7:0] REG_XTAL = 8'h12;
	localparam logic [7:0] REG_SRC = 8'h13;
	localparam logic [7:0] REG_DRV_EN = 8'h14;
	localparam logic [7:0] REG_GATE_EN = 8'h15;
	localparam logic [7:0] REG_OTP_CMD = 8'h72;
	localparam logic [7:0] REG_STATUS = 8'h73;

	// storage index of each configuration register
	localparam logic [2:0] IDX_ADDR_SEL = 3'h0;
	localparam logic [2:0] IDX_OUT_CTRL = 3'h1;
	localparam logic [2:0] IDX_XTAL = 3'h2;
	localparam logic [2:0] IDX_SRC = 3'h3;
	localparam logic [2:0] IDX_DRV_EN = 3'h4;
	localparam logic [2:0] IDX_GATE_EN = 3'h5;
	localparam logic [2:0] IDX_NONE = 3'h7;

	// field positions
	localparam int ADDR_SEL_BIT = 0;
	localparam int SH_BIT = 0;
	localparam int SP_BIT = 1;
	localparam int PRIMARY_SOURCE_BIT_BIT = 1;
	localparam int SM_HI_BIT = 7;
	localparam int SAVE_BIT = 3;
	localparam int RESTORE_BIT = 0;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_DIFF_BIT = 1;
	localparam int ST_SHDN_BIT = 2;
	localparam int ST_GATE_BIT = 3;

	// writable bits of each register, reserved bits read zero
	localparam logic [7:0] MASK_ADDR_SEL = 8'h01;
	localparam logic [7:0] MASK_OUT_CTRL = 8'h03;
	localparam logic [7:0] MASK_XTAL = 8'h3f;
	localparam logic [7:0] MASK_SRC = 8'hc2;
	localparam logic [7:0] MASK_OUT_BITS = 8'hff;

	// factory otp image, index 5 down to 0
	localparam logic [NUM_CFG*8-1:0] OTP_FACTORY = 48'h0007_000b_0000;

	// i2c slave addresses and command codes
	localparam logic [6:0] I2C_ADDR_DEFAULT = 7'h6a;
	localparam logic [6:0] I2C_ADDR_ALT = 7'h68;
	localparam logic [7:0] CMD_SAVE = 8'h08;
	localparam logic [7:0] CMD_RESTORE = 8'h01;

	// timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int OTP_OP_NS = 2000;
	localparam int OTP_OP_CYC = (OTP_OP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SW_GAP_NS = 200;
	localparam int SW_GAP_CYC = (SW_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		OUT_ACTIVE = 2'h0,
		OUT_STATIC = 2'h1,
		OUT_TRISTATE = 2'h2,
		OUT_SHUTDOWN = 2'h3
	} rcsog_out_mode_t;

	typedef enum logic [2:0] {
		I2C_IDLE = 3'h0,
		I2C_ADDR = 3'h1,
		I2C_ACK_A = 3'h2,
		I2C_DATA = 3'h3,
		I2C_ACK_D = 3'h4,
		I2C_IGNORE = 3'h5
	} rcsog_i2c_state_t;

	typedef enum logic [1:0] {
		SW_IDLE = 2'h0,
		SW_GATED = 2'h1,
		SW_SETTLE = 2'h2
	} rcsog_sw_state_t;

endpackage : rcsog_pkg

/* File: logic/rcsog_src_switch.sv */
// Purpose: break-before-make change of the reference source
// Assumes: want_diff already synchronised to sys_clk
// Notes: outputs are gated for SW_GAP_CYC before and after the mux moves
`timescale 1ns/1ps
module rcsog_src_switch #(
	parameter int GAP_CYC = rcsog_pkg::SW_GAP_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// control side
	rcsog_sw_if.sw swl
);

	if (GAP_CYC < 1 || GAP_CYC > 255) begin : g_chk
		$error("gap count out of range");
	end

	rcsog_pkg::rcsog_sw_state_t state_reg;
	logic [7:0] gap_reg;
	logic sel_reg;
	logic gate_reg;

	// gate first, move the mux while quiet, then release: no runt pulse
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= rcsog_pkg::SW_IDLE;
			gap_reg <= 8'h00;
			sel_reg <= 1'b0;
			gate_reg <= 1'b1;
		end else begin
			case (state_reg)
				rcsog_pkg::SW_IDLE: begin
					if (swl.want_diff != sel_reg) begin
						gate_reg <= 1'b0;
						gap_reg <= 8'(GAP_CYC - 1);
						state_reg <= rcsog_pkg::SW_GATED;
					end
				end
				rcsog_pkg::SW_GATED: begin
					if (gap_reg == 8'h00) begin
						sel_reg <= swl.want_diff;
						gap_reg <= 8'(GAP_CYC - 1);
						state_reg <= rcsog_pkg::SW_SETTLE;
					end else begin
						gap_reg <= gap_reg - 8'h01;
					end
				end
				rcsog_pkg::SW_SETTLE: begin
					if (gap_reg == 8'h00) begin
						gate_reg <= 1'b1;
						state_reg <= rcsog_pkg::SW_IDLE;
					end else begin
						gap_reg <= gap_reg - 8'h01;
					end
				end
				default: begin
					gate_reg <= 1'b1;
					state_reg <= rcsog_pkg::SW_IDLE;
				end
			endcase
		end
	end

	assign swl.sel_diff = sel_reg;
	assign swl.gate_en = gate_reg;
	assign swl.busy = (state_reg != rcsog_pkg::SW_IDLE);

endmodule : rcsog_src_switch

/* File: logic/rcsog_sw_if.sv */
// Purpose: link between selection control and the glitchless source switch
// Assumes: both ends on sys_clk
// Notes: busy is high from a request until the outputs are ungated again
`timescale 1ns/1ps
interface rcsog_sw_if;
	logic want_diff;
	logic sel_diff;
	logic gate_en;
	logic busy;
	modport ctrl (output want_diff, input sel_diff, input gate_en, input busy);
	modport sw (input want_diff, output sel_diff, output gate_en, output busy);
endinterface : rcsog_sw_if

/* File: logic/rcsog_top.sv */
// Purpose: reference select, crystal trim, otp save/restore and output gating control
// Assumes: pins and i2c lines are asynchronous to sys_clk, scl well below sys_clk / 4
// Notes: nrst stands for the internal power-on reset
`timescale 1ns/1ps
module rcsog_top #(
	parameter int NUM_OUT = 3,
	parameter int OTP_CYC = rcsog_pkg::OTP_OP_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// register port
	input wire logic [rcsog_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [rcsog_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [rcsog_pkg::DATA_W-1:0] reg_rdata,
	// control pins
	input wire logic input_source_select_pin,
	input wire logic shutdown_enable_pin,
	// i2c pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	// reference and trim
	output logic ref_sel_diff,
	output logic ref_gate_en,
	output logic [rcsog_pkg::XTAL_W-1:0] crystal_load_trim,
	// outputs
	output logic [2*NUM_OUT-1:0] out_mode,
	output logic global_shutdown,
	output logic otp_busy
);

	if (NUM_OUT < 1 || NUM_OUT > 8) begin : g_chk_out
		$error("NUM_OUT must be 1 to 8");
	end
	if (OTP_CYC < 1 || OTP_CYC > 65535) begin : g_chk_otp
		$error("OTP_CYC out of range");
	end

	function automatic logic [2:0] cfg_index(input logic [7:0] a);
		case (a)
			rcsog_pkg::REG_ADDR_SEL: cfg_index = rcsog_pkg::IDX_ADDR_SEL;
			rcsog_pkg::REG_OUT_CTRL: cfg_index = rcsog_pkg::IDX_OUT_CTRL;
			rcsog_pkg::REG_XTAL: cfg_index = rcsog_pkg::IDX_XTAL;
			rcsog_pkg::REG_SRC: cfg_index = rcsog_pkg::IDX_SRC;
			rcsog_pkg::REG_DRV_EN: cfg_index = rcsog_pkg::IDX_DRV_EN;
			rcsog_pkg::REG_GATE_EN: cfg_index = rcsog_pkg::IDX_GATE_EN;
			default: cfg_index = rcsog_pkg::IDX_NONE;
		endcase
	endfunction : cfg_index

	function automatic logic [7:0] cfg_mask(input logic [2:0] idx);
		case (idx)
			rcsog_pkg::IDX_ADDR_SEL: cfg_mask = rcsog_pkg::MASK_ADDR_SEL;
			rcsog_pkg::IDX_OUT_CTRL: cfg_mask = rcsog_pkg::MASK_OUT_CTRL;
			rcsog_pkg::IDX_XTAL: cfg_mask = rcsog_pkg::MASK_XTAL;
			rcsog_pkg::IDX_SRC: cfg_mask = rcsog_pkg::MASK_SRC;
			default: cfg_mask = rcsog_pkg::MASK_OUT_BITS;
		endcase
	endfunction : cfg_mask

	logic [3:0] sync1_reg;
	logic [3:0] sync2_reg;
	logic [1:0] i2c_d_reg;
	logic sel_pin_s;
	logic sd_pin_s;
	logic scl_s;
	logic sda_s;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sync1_reg <= 4'hf;
			sync2_reg <= 4'hf;
			i2c_d_reg <= 2'h3;
		end else begin
			sync1_reg <= {input_source_select_pin, shutdown_enable_pin, scl_in, sda_in};
			sync2_reg <= sync1_reg;
			i2c_d_reg <= sync2_reg[1:0];
		end
	end

	assign sel_pin_s = sync2_reg[3];
	assign sd_pin_s = sync2_reg[2];
	assign scl_s = sync2_reg[1];
	assign sda_s = sync2_reg[0];

	// configuration and otp storage
	logic [7:0] cfg_reg [rcsog_pkg::NUM_CFG];
	logic [7:0] otp_reg [rcsog_pkg::NUM_CFG];
	logic [2:0] wr_idx;
	logic restore_done;
	logic save_done;
	logic busy;

	assign wr_idx = cfg_index(reg_addr);

	// register writes are dropped while an otp operation runs
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < rcsog_pkg::NUM_CFG; i++) begin
				cfg_reg[i] <= 8'h00;
			end
		end else if (restore_done) begin
			for (int i = 0; i < rcsog_pkg::NUM_CFG; i++) begin
				cfg_reg[i] <= otp_reg[i];
			end
		end else if (reg_wr && !busy && wr_idx != rcsog_pkg::IDX_NONE) begin
			cfg_reg[wr_idx] <= reg_wdata & cfg_mask(wr_idx);
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < rcsog_pkg::NUM_CFG; i++) begin
				otp_reg[i] <= rcsog_pkg::OTP_FACTORY[i*8 +: 8];
			end
		end else if (save_done) begin
			for (int i = 0; i < rcsog_pkg::NUM_CFG; i++) begin
				otp_reg[i] <= cfg_reg[i];
			end
		end
	end

	// i2c command slave
	rcsog_pkg::rcsog_i2c_state_t i2c_state_reg;
	logic [7:0] shift_reg;
	logic [3:0] bit_cnt_reg;
	logic [1:0] byte_cnt_reg;
	logic [7:0] cmd_reg;
	logic sda_oe_n_reg;
	logic i2c_save;
	logic i2c_restore;
	logic scl_rise;
	logic scl_fall;
	logic i2c_start;
	logic i2c_stop;
	logic addr_match;
	logic [6:0] my_addr;

	assign scl_rise = scl_s && !i2c_d_reg[1];
	assign scl_fall = !scl_s && i2c_d_reg[1];
	assign i2c_start = scl_s && i2c_d_reg[1] && i2c_d_reg[0] && !sda_s;
	assign i2c_stop = scl_s && i2c_d_reg[1] && !i2c_d_reg[0] && sda_s;
	assign my_addr = cfg_reg[rcsog_pkg::IDX_ADDR_SEL][rcsog_pkg::ADDR_SEL_BIT] ?
		rcsog_pkg::I2C_ADDR_ALT : rcsog_pkg::I2C_ADDR_DEFAULT;
	// only a write-direction address byte is claimed
	assign addr_match = (shift_reg[7:1] == my_addr) && !shift_reg[0];
	assign i2c_save = i2c_stop && i2c_state_reg != rcsog_pkg::I2C_IDLE &&
		byte_cnt_reg == 2'h1 && cmd_reg == rcsog_pkg::CMD_SAVE;
	assign i2c_restore = i2c_stop && i2c_state_reg != rcsog_pkg::I2C_IDLE &&
		byte_cnt_reg == 2'h1 && cmd_reg == rcsog_pkg::CMD_RESTORE;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			i2c_state_reg <= rcsog_pkg::I2C_IDLE;
			shift_reg <= 8'h00;
			bit_cnt_reg <= 4'h0;
			byte_cnt_reg <= 2'h0;
			cmd_reg <= 8'h00;
			sda_oe_n_reg <= 1'b1;
		end else if (i2c_stop) begin
			i2c_state_reg <= rcsog_pkg::I2C_IDLE;
			sda_oe_n_reg <= 1'b1;
		end else if (i2c_start) begin
			i2c_state_reg <= rcsog_pkg::I2C_ADDR;
			bit_cnt_reg <= 4'h0;
			byte_cnt_reg <= 2'h0;
			sda_oe_n_reg <= 1'b1;
		end else if (scl_rise) begin
			shift_reg <= {shift_reg[6:0], sda_s};
			bit_cnt_reg <= bit_cnt_reg + 4'h1;
		end else if (scl_fall) begin
			case (i2c_state_reg)
				rcsog_pkg::I2C_ADDR: begin
					if (bit_cnt_reg == 4'h8) begin
						if (addr_match && !busy) begin
							sda_oe_n_reg <= 1'b0;
							i2c_state_reg <= rcsog_pkg::I2C_ACK_A;
						end else begin
							i2c_state_reg <= rcsog_pkg::I2C_IGNORE;
						end
					end
				end
				rcsog_pkg::I2C_DATA: begin
					if (bit_cnt_reg == 4'h8) begin
						if (!busy) begin
							sda_oe_n_reg <= 1'b0;
							i2c_state_reg <= rcsog_pkg::I2C_ACK_D;
							if (byte_cnt_reg == 2'h0) begin
								cmd_reg <= shift_reg;
							end
							if (byte_cnt_reg != 2'h3) begin
								byte_cnt_reg <= byte_cnt_reg + 2'h1;
							end
						end else begin
							i2c_state_reg <= rcsog_pkg::I2C_IGNORE;
						end
					end
				end
				rcsog_pkg::I2C_ACK_A, rcsog_pkg::I2C_ACK_D: begin
					sda_oe_n_reg <= 1'b1;
					bit_cnt_reg <= 4'h0;
					i2c_state_reg <= rcsog_pkg::I2C_DATA;
				end
				rcsog_pkg::I2C_IDLE, rcsog_pkg::I2C_IGNORE: begin
					sda_oe_n_reg <= 1'b1;
				end
				default: begin
					sda_oe_n_reg <= 1'b1;
					i2c_state_reg <= rcsog_pkg::I2C_IDLE;
				end
			endcase
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe_n = sda_oe_n_reg;

	// otp sequencer
	logic boot_pend_reg;
	logic op_run_reg;
	logic op_save_reg;
	logic [15:0] op_cnt_reg;
	logic bus_save;
	logic bus_restore;
	logic req_save;
	logic req_restore;

	assign bus_save = reg_wr && reg_addr == rcsog_pkg::REG_OTP_CMD &&
		reg_wdata[rcsog_pkg::SAVE_BIT];
	assign bus_restore = reg_wr && reg_addr == rcsog_pkg::REG_OTP_CMD &&
		reg_wdata[rcsog_pkg::RESTORE_BIT];
	// save wins when both are asked in one cycle, except against the pending boot restore
	assign req_save = bus_save || i2c_save;
	assign req_restore = boot_pend_reg || bus_restore || i2c_restore;
	assign busy = op_run_reg || boot_pend_reg;
	assign restore_done = op_run_reg && !op_save_reg && op_cnt_reg == 16'h0000;
	assign save_done = op_run_reg && op_save_reg && op_cnt_reg == 16'h0000;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			boot_pend_reg <= 1'b1;
			op_run_reg <= 1'b0;
			op_save_reg <= 1'b0;
			op_cnt_reg <= 16'h0000;
		end else if (op_run_reg) begin
			if (op_cnt_reg == 16'h0000) begin
				op_run_reg <= 1'b0;
			end else begin
				op_cnt_reg <= op_cnt_reg - 16'h0001;
			end
		end else if (req_save || req_restore) begin
			boot_pend_reg <= 1'b0;
			op_run_reg <= 1'b1;
			op_save_reg <= req_save && !boot_pend_reg;
			op_cnt_reg <= 16'(OTP_CYC - 1);
		end
	end

	assign otp_busy = busy;

	// reference selection
	rcsog_sw_if swl ();
	logic want_diff_reg;
	logic manual_mode;

	assign manual_mode = !cfg_reg[rcsog_pkg::IDX_SRC][rcsog_pkg::SM_HI_BIT];

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			want_diff_reg <= 1'b0;
		end else if (manual_mode && !busy) begin
			want_diff_reg <= sel_pin_s ^ cfg_reg[rcsog_pkg::IDX_SRC][rcsog_pkg::PRIMARY_SOURCE_BIT_BIT];
		end
	end

	assign swl.want_diff = want_diff_reg;

	rcsog_src_switch #(
		.GAP_CYC(rcsog_pkg::SW_GAP_CYC)
	) u_switch (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.swl(swl)
	);

	assign ref_sel_diff = swl.sel_diff;
	assign ref_gate_en = swl.gate_en;

	assign crystal_load_trim = cfg_reg[rcsog_pkg::IDX_XTAL][rcsog_pkg::XTAL_W-1:0];

	// output gating
	logic pin_func_sd;
	logic pin_pol;
	logic shutdown_now;
	logic pin_disable;
	logic [2*NUM_OUT-1:0] mode_next;
	logic [2*NUM_OUT-1:0] mode_reg;
	logic shdn_reg;

	assign pin_func_sd = cfg_reg[rcsog_pkg::IDX_OUT_CTRL][rcsog_pkg::SH_BIT];
	assign pin_pol = cfg_reg[rcsog_pkg::IDX_OUT_CTRL][rcsog_pkg::SP_BIT];
	assign shutdown_now = pin_func_sd && sd_pin_s;
	assign pin_disable = sd_pin_s ^ pin_pol;

	always_comb begin
		mode_next = '0;
		for (int i = 0; i < NUM_OUT; i++) begin
			if (busy) begin
				mode_next[2*i +: 2] = rcsog_pkg::OUT_TRISTATE;
			end else if (shutdown_now) begin
				mode_next[2*i +: 2] = rcsog_pkg::OUT_SHUTDOWN;
			end else if (!cfg_reg[rcsog_pkg::IDX_DRV_EN][i]) begin
				mode_next[2*i +: 2] = rcsog_pkg::OUT_TRISTATE;
			end else if (cfg_reg[rcsog_pkg::IDX_GATE_EN][i] && pin_disable) begin
				mode_next[2*i +: 2] = rcsog_pkg::OUT_STATIC;
			end else begin
				mode_next[2*i +: 2] = rcsog_pkg::OUT_ACTIVE;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			mode_reg <= {NUM_OUT{rcsog_pkg::OUT_TRISTATE}};
			shdn_reg <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			shdn_reg <= shutdown_now && !busy;
		end
	end

	assign out_mode = mode_reg;
	assign global_shutdown = shdn_reg;

	// read port, data valid only in the cycle after the strobe
	logic [2:0] rd_idx;
	logic [7:0] rd_val;

	assign rd_idx = cfg_index(reg_addr);

	always_comb begin
		rd_val = 8'h00;
		if (rd_idx != rcsog_pkg::IDX_NONE) begin
			rd_val = cfg_reg[rd_idx];
		end else if (reg_addr == rcsog_pkg::REG_OTP_CMD) begin
			rd_val = 8'h00;
		end else if (reg_addr == rcsog_pkg::REG_STATUS) begin
			rd_val[rcsog_pkg::ST_BUSY_BIT] = busy;
			rd_val[rcsog_pkg::ST_DIFF_BIT] = swl.sel_diff;
			rd_val[rcsog_pkg::ST_SHDN_BIT] = shdn_reg;
			rd_val[rcsog_pkg::ST_GATE_BIT] = swl.gate_en;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rd_val;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

endmodule : rcsog_top
